// ---- hw/paw_pkg.sv ----
/*
 Constants for the protected-area authenticated write: frame layout,
 message types, result codes, the counter limit and the status error bit.
 Assumes one clock domain and byte-wide frame transfer over paw_if.
*/
// Summary of operation
// R1: Write starts on send frame type 0003h
// R2: Expired counter gives result 0005h, no write
// R3: Then bad address gives 0004h, no write
// R4: Then tag mismatch gives 0002h, no write
// R5: Then counter mismatch gives 0003h, no write
// R6: All pass: write data, counter plus one
// R7: Programming failure reports 0005h
// R8: Other write errors report 0001h
// R9: Host verifies with type 0005h, zero fields
// R10: Device completes verify send when result ready
// R11: Host then fetches result with receive
// R12: Response 0300h: nonce, counter, address, tag, result; code sends the tag bytes as 00h
// R13: Fixed byte positions for all frame fields
// R14: Host sends current counter, sectors, zero result
// R15: Target byte 223 is 00h both ways
// R16: Full success reports result 0000h
package paw_pkg;
    localparam int FRAME_BYTES  = 256;
    localparam int TAG_LO       = 191;
    localparam int TAG_HI       = 222;
    localparam int TARGET_BYTE  = 223;
    localparam int NONCE_LO     = 224;
    localparam int WCNT_LO      = 240;
    localparam int ADDR_LO      = 244;
    localparam int SCNT_LO      = 248;
    localparam int RES_LO       = 252;
    localparam int TYPE_LO      = 254;
    localparam logic [7:0]  TARGET_ID    = 8'h00;
    localparam logic [15:0] REQ_WRITE    = 16'h0003;
    localparam logic [15:0] REQ_VERIFY   = 16'h0005;
    localparam logic [15:0] RSP_WRITE    = 16'h0300;
    localparam logic [15:0] RES_OK       = 16'h0000;
    localparam logic [15:0] RES_GENERAL  = 16'h0001;
    localparam logic [15:0] RES_AUTH     = 16'h0002;
    localparam logic [15:0] RES_COUNTER  = 16'h0003;
    localparam logic [15:0] RES_ADDRESS  = 16'h0004;
    localparam logic [15:0] RES_WRFAIL   = 16'h0005;
    localparam logic [31:0] WCNT_MAX     = 32'hffffffff;
    localparam logic [7:0]  STAT_ERR_BIT = 8'h01;
endpackage

// ---- hw/paw_if.sv ----
/*
 Link between host end and device end: byte stream of one frame per
 command, with command kind and a completion status back.
 Assumes the bench joins both modports; one shared clock.
*/
`timescale 1ns/1ns
interface paw_if;
    logic       cmdStart;
    logic       cmdIsSend;
    logic       byteValid;
    logic [7:0] byteData;
    logic       rspValid;
    logic [7:0] rspData;
    logic       cmdDone;
    logic       cmdOk;
    modport host
    (
        output cmdStart, cmdIsSend, byteValid, byteData,
        input  rspValid, rspData, cmdDone, cmdOk
    );
    modport dev
    (
        input  cmdStart, cmdIsSend, byteValid, byteData,
        output rspValid, rspData, cmdDone, cmdOk
    );
endinterface

// ---- hw/paw_tag_fold.sv ----
/*
 Folding auth tag calculator: xors each fed byte into a 32-byte
 accumulator, rotated per byte. Stand-in for the keyed tag function.
 Assumes the caller clears before each frame.
*/
`timescale 1ns/1ns
module paw_tag_fold
    import paw_pkg::*;
#(
    parameter int TAG_BYTES = 32
)
(
    input  wire logic                   mclk,
    input  wire logic                   rst_n,
    input  wire logic                   clear,
    input  wire logic                   feed,
    input  wire logic [7:0]             feedByte,
    output logic [8*TAG_BYTES-1:0]      tagOut
);
    logic [8*TAG_BYTES-1:0] tag_reg;
    logic [8*TAG_BYTES-1:0] tag_next;
    always_comb
    begin
        tag_next = tag_reg;
        if (clear)
            tag_next = '0;
        else if (feed)
            tag_next = {tag_reg[8*TAG_BYTES-9:0],
                        tag_reg[8*TAG_BYTES-1 -: 8] ^ feedByte};
    end
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            tag_reg <= '0;
        else
            tag_reg <= tag_next;
    end
    assign tagOut = tag_reg;
endmodule

// ---- hw/paw_device.sv ----
/*
 Device end: takes write and verify frames, runs the ordered checks,
 programs the protected area and answers the result frame.
 Assumes host keeps the send/verify/receive order; one clock.
*/
// The address-and-strobe port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
module paw_device
    import paw_pkg::*;
#(
    parameter int DEPTH = 16,
    parameter int BLK   = 4
)
(
    paw_if.dev                 link,
    input  wire logic          mclk,
    input  wire logic          rst_n,
    input  wire logic          progFail,
    input  wire logic          genFail,
    input  wire logic          statusRd,
    output logic [7:0]         status,
    output logic               irq,
    output logic [31:0]        wcntOut,
    output logic [8*BLK-1:0]   areaWord,
    input  wire logic [31:0]   areaAddr,
    input  wire logic [7:0]    maskIn
);
    typedef enum logic [2:0]
    {
        S_IDLE = 3'b000,
        S_RECV = 3'b001,
        S_EVAL = 3'b010,
        S_DONE = 3'b011,
        S_SEND = 3'b100
    } paw_dst_t;

    paw_dst_t               st_reg, st_next;
    logic [7:0]             frm_reg [FRAME_BYTES+BLK];
    logic [7:0]             frm_next [FRAME_BYTES+BLK];
    logic [8:0]             idx_reg, idx_next;
    logic [31:0]            wcnt_reg, wcnt_next;
    logic [15:0]            res_reg, res_next;
    logic [127:0]           nonce_reg, nonce_next;
    logic [31:0]            addr_reg, addr_next;
    logic [8*BLK-1:0]       area_reg [DEPTH];
    logic [8*BLK-1:0]       area_next [DEPTH];
    logic                   isWrite_reg, isWrite_next;
    logic                   done_reg, done_next, ok_reg, ok_next;
    logic                   rv_reg, rv_next;
    logic [7:0]             rd_reg, rd_next;
    logic [7:0]             stat_reg, stat_next;
    logic                   irq_reg;
    logic [255:0]           tagCalc;
    logic                   tagClr, tagFeed;
    logic [7:0]             tagByte;
    logic [15:0]            rqType;
    logic [31:0]            rqCnt, rqAddr;
    logic                   tagOk;

    paw_tag_fold #(.TAG_BYTES(32)) u_tag
    (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .clear    (tagClr),
        .feed     (tagFeed),
        .feedByte (tagByte),
        .tagOut   (tagCalc)
    );

    // Big-endian fields, byte 255 first on the link
    always_comb
    begin
        rqType = {frm_reg[TYPE_LO+BLK+1], frm_reg[TYPE_LO+BLK]};  // see R13
        rqCnt  = {frm_reg[WCNT_LO+BLK+3], frm_reg[WCNT_LO+BLK+2],
                  frm_reg[WCNT_LO+BLK+1], frm_reg[WCNT_LO+BLK]};
        rqAddr = {frm_reg[ADDR_LO+BLK+3], frm_reg[ADDR_LO+BLK+2],
                  frm_reg[ADDR_LO+BLK+1], frm_reg[ADDR_LO+BLK]};
        tagOk  = 1'b1;
        for (int i = 0; i < 32; i++)
            if (frm_reg[TAG_LO+BLK+i] != tagCalc[8*i +: 8])
                tagOk = 1'b0;
    end

    always_comb
    begin
        st_next      = st_reg;
        frm_next     = frm_reg;
        idx_next     = idx_reg;
        wcnt_next    = wcnt_reg;
        res_next     = res_reg;
        nonce_next   = nonce_reg;
        addr_next    = addr_reg;
        area_next    = area_reg;
        isWrite_next = isWrite_reg;
        done_next    = 1'b0;
        ok_next      = 1'b0;
        rv_next      = 1'b0;
        rd_next      = 8'h00;
        stat_next    = statusRd ? 8'h00 : stat_reg;
        tagClr       = 1'b0;
        tagFeed      = 1'b0;
        tagByte      = 8'h00;
        unique case (st_reg)
            S_IDLE:
            begin
                if (link.cmdStart)
                begin
                    idx_next = 9'(FRAME_BYTES + BLK - 1);
                    tagClr   = 1'b1;
                    st_next  = link.cmdIsSend ? S_RECV : S_SEND;
                end
            end
            S_RECV:
            begin
                if (link.byteValid)
                begin
                    frm_next[idx_reg] = link.byteData;
                    // Tag covers all bytes except the tag field, data included
                    if (idx_reg < 9'(TAG_LO + BLK)
                        || idx_reg >= 9'(TARGET_BYTE + BLK))
                    begin
                        tagFeed = 1'b1;
                        tagByte = link.byteData;
                    end
                    if (idx_reg == 9'd0)
                        st_next = S_EVAL;
                    else
                        idx_next = idx_reg - 9'd1;
                end
            end
            S_EVAL:
            begin
                st_next = S_DONE;
                if (frm_reg[TARGET_BYTE+BLK] != TARGET_ID)    // see R15
                    res_next = RES_GENERAL;
                else if (rqType == REQ_WRITE)                 // see R1
                begin
                    isWrite_next = 1'b1;
                    for (int n = 0; n < 16; n++)
                        nonce_next[8*n +: 8] = frm_reg[NONCE_LO + BLK + n];
                    addr_next = rqAddr;
                    if (wcnt_reg == WCNT_MAX)
                        res_next = RES_WRFAIL;                // see R2
                    else if (rqAddr >= 32'(DEPTH))
                        res_next = RES_ADDRESS;               // see R3
                    else if (!tagOk)
                        res_next = RES_AUTH;                  // see R4
                    else if (rqCnt != wcnt_reg)
                        res_next = RES_COUNTER;               // see R5
                    else if (progFail)
                        res_next = RES_WRFAIL;                // see R7
                    else if (genFail)
                        res_next = RES_GENERAL;               // see R8
                    else
                    begin
                        for (int b = 0; b < BLK; b++)         // see R6
                            area_next[rqAddr[$clog2(DEPTH)-1:0]][8*b +: 8]
                                = frm_reg[BLK-1-b];
                        wcnt_next = wcnt_reg + 32'd1;
                        res_next  = RES_OK;                   // see R16
                    end
                end
                else if (rqType != REQ_VERIFY)
                    res_next = RES_GENERAL;
            end
            S_DONE:
            begin
                done_next = 1'b1;                             // see R10
                ok_next   = 1'b1;
                if (res_reg != RES_OK)
                    stat_next = stat_reg | STAT_ERR_BIT;
                st_next = S_IDLE;
            end
            S_SEND:
            begin
                rv_next  = 1'b1;
                // Response frame, byte 255 first; see R12
                if (idx_reg == 9'(TYPE_LO + BLK + 1))
                    rd_next = RSP_WRITE[15:8];
                else if (idx_reg == 9'(TYPE_LO + BLK))
                    rd_next = RSP_WRITE[7:0];
                else if (idx_reg >= 9'(RES_LO + BLK))
                    rd_next = res_reg[8*(idx_reg-9'(RES_LO+BLK)) +: 8];
                else if (idx_reg >= 9'(ADDR_LO + BLK)
                         && idx_reg < 9'(SCNT_LO + BLK))
                    rd_next = addr_reg[8*(idx_reg-9'(ADDR_LO+BLK)) +: 8];
                else if (idx_reg >= 9'(WCNT_LO + BLK)
                         && idx_reg < 9'(ADDR_LO + BLK))
                    rd_next = wcnt_reg[8*(idx_reg-9'(WCNT_LO+BLK)) +: 8];
                else if (idx_reg >= 9'(NONCE_LO + BLK)
                         && idx_reg < 9'(WCNT_LO + BLK))
                    rd_next = nonce_reg[8*(idx_reg-9'(NONCE_LO+BLK)) +: 8];
                else if (idx_reg == 9'(TARGET_BYTE + BLK))
                    rd_next = TARGET_ID;                      // see R15
                else if (idx_reg >= 9'(TAG_LO + BLK)
                         && idx_reg < 9'(TARGET_BYTE + BLK))
                    rd_next = tagCalc[8*(idx_reg-9'(TAG_LO+BLK)) +: 8];
                if (idx_reg == 9'(BLK))
                begin
                    done_next = 1'b1;
                    ok_next   = 1'b1;
                    st_next   = S_IDLE;
                end
                else
                    idx_next = idx_reg - 9'd1;
            end
            default:
                st_next = S_IDLE;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            st_reg      <= S_IDLE;
            idx_reg     <= '0;
            wcnt_reg    <= '0;
            res_reg     <= RES_OK;
            nonce_reg   <= '0;
            addr_reg    <= '0;
            isWrite_reg <= 1'b0;
            done_reg    <= 1'b0;
            ok_reg      <= 1'b0;
            rv_reg      <= 1'b0;
            rd_reg      <= 8'h00;
            stat_reg    <= 8'h00;
            irq_reg     <= 1'b0;
            for (int i = 0; i < FRAME_BYTES + BLK; i++)
                frm_reg[i] <= 8'h00;
            for (int i = 0; i < DEPTH; i++)
                area_reg[i] <= '0;
        end
        else
        begin
            st_reg      <= st_next;
            idx_reg     <= idx_next;
            wcnt_reg    <= wcnt_next;
            res_reg     <= res_next;
            nonce_reg   <= nonce_next;
            addr_reg    <= addr_next;
            isWrite_reg <= isWrite_next;
            done_reg    <= done_next;
            ok_reg      <= ok_next;
            rv_reg      <= rv_next;
            rd_reg      <= rd_next;
            stat_reg    <= stat_next;
            irq_reg     <= |(stat_next & maskIn);
            frm_reg     <= frm_next;
            area_reg    <= area_next;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            status   <= 8'h00;
            wcntOut  <= '0;
            areaWord <= '0;
        end
        else
        begin
            status   <= stat_reg;
            wcntOut  <= wcnt_reg;
            areaWord <= area_reg[areaAddr[$clog2(DEPTH)-1:0]];
        end
    end

    assign link.cmdDone  = done_reg;
    assign link.cmdOk    = ok_reg;
    assign link.rspValid = rv_reg;
    assign link.rspData  = rd_reg;
    assign irq           = irq_reg;
endmodule

// ---- hw/paw_host.sv ----
/*
 Host end: on go, sends a write frame, then a verify frame, then a
 receive, and hands back the result code and returned counter.
 Assumes the device end answers on the same clock.
*/
`timescale 1ns/1ns
module paw_host
    import paw_pkg::*;
#(
    parameter int BLK = 4
)
(
    paw_if.host                link,
    input  wire logic          mclk,
    input  wire logic          rst_n,
    input  wire logic          go,
    input  wire logic [31:0]   addr,
    input  wire logic [31:0]   curCnt,
    input  wire logic [127:0]  nonce,
    input  wire logic [8*BLK-1:0] data,
    input  wire logic [255:0]  tag,
    output logic               busy,
    output logic               finished,
    output logic [15:0]        result,
    output logic [31:0]        newCnt
);
    typedef enum logic [2:0]
    {
        H_IDLE = 3'b000,
        H_WR   = 3'b001,
        H_WWT  = 3'b010,
        H_VF   = 3'b011,
        H_VWT  = 3'b100,
        H_RX   = 3'b101
    } paw_hst_t;

    paw_hst_t      st_reg, st_next;
    logic [8:0]    idx_reg, idx_next;
    logic          start_reg, start_next, snd_reg, snd_next;
    logic          bv_reg, bv_next;
    logic [7:0]    bd_reg, bd_next;
    logic [15:0]   res_reg, res_next;
    logic [31:0]   cnt_reg, cnt_next;
    logic          fin_reg, fin_next;
    logic          vfy;
    logic [7:0]    frameByte;
    logic [8:0]    j;

    // Byte of the outgoing frame at index idx_reg; see R13 and R14
    always_comb
    begin
        j = idx_reg - 9'(BLK);
        frameByte = 8'h00;
        vfy = (st_reg == H_VF);
        if (idx_reg < 9'(BLK))
            frameByte = vfy ? 8'h00 : data[8*(BLK-1-idx_reg) +: 8];
        else if (j == 9'(TYPE_LO + 1))
            frameByte = vfy ? REQ_VERIFY[15:8] : REQ_WRITE[15:8]; // see R1
        else if (j == 9'(TYPE_LO))
            frameByte = vfy ? REQ_VERIFY[7:0] : REQ_WRITE[7:0];   // see R9
        else if (vfy || j >= 9'(RES_LO))
            frameByte = 8'h00;
        else if (j >= 9'(SCNT_LO))
            frameByte = (j == 9'(SCNT_LO)) ? 8'h01 : 8'h00;
        else if (j >= 9'(ADDR_LO))
            frameByte = addr[8*(j-9'(ADDR_LO)) +: 8];
        else if (j >= 9'(WCNT_LO))
            frameByte = curCnt[8*(j-9'(WCNT_LO)) +: 8];
        else if (j >= 9'(NONCE_LO))
            frameByte = nonce[8*(j-9'(NONCE_LO)) +: 8];
        else if (j == 9'(TARGET_BYTE))
            frameByte = TARGET_ID;                               // see R15
        else if (j >= 9'(TAG_LO))
            frameByte = tag[8*(j-9'(TAG_LO)) +: 8];
    end

    always_comb
    begin
        st_next    = st_reg;
        idx_next   = idx_reg;
        start_next = 1'b0;
        snd_next   = snd_reg;
        bv_next    = 1'b0;
        bd_next    = 8'h00;
        res_next   = res_reg;
        cnt_next   = cnt_reg;
        fin_next   = 1'b0;
        unique case (st_reg)
            H_IDLE:
            begin
                if (go)
                begin
                    st_next    = H_WR;
                    start_next = 1'b1;
                    snd_next   = 1'b1;
                    idx_next   = 9'(FRAME_BYTES + BLK - 1);
                end
            end
            H_WR, H_VF:
            begin
                bv_next = 1'b1;
                bd_next = frameByte;
                if (idx_reg == 9'd0)
                    st_next = (st_reg == H_WR) ? H_WWT : H_VWT;
                else
                    idx_next = idx_reg - 9'd1;
            end
            H_WWT:
            begin
                if (link.cmdDone)
                begin
                    st_next    = H_VF;                           // see R9
                    start_next = 1'b1;
                    idx_next   = 9'(FRAME_BYTES + BLK - 1);
                end
            end
            H_VWT:
            begin
                if (link.cmdDone && link.cmdOk)
                begin
                    st_next    = H_RX;                           // see R11
                    start_next = 1'b1;
                    snd_next   = 1'b0;
                    idx_next   = 9'(FRAME_BYTES + BLK - 1);
                end
            end
            H_RX:
            begin
                if (link.rspValid)
                begin
                    if (idx_reg >= 9'(RES_LO + BLK)
                        && idx_reg < 9'(TYPE_LO + BLK))
                        res_next[8*(idx_reg-9'(RES_LO+BLK)) +: 8]
                            = link.rspData;
                    if (idx_reg >= 9'(WCNT_LO + BLK)
                        && idx_reg < 9'(ADDR_LO + BLK))
                        cnt_next[8*(idx_reg-9'(WCNT_LO+BLK)) +: 8]
                            = link.rspData;
                    idx_next = idx_reg - 9'd1;
                end
                if (link.cmdDone)
                begin
                    fin_next = 1'b1;
                    st_next  = H_IDLE;
                end
            end
            default:
                st_next = H_IDLE;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            st_reg    <= H_IDLE;
            idx_reg   <= '0;
            start_reg <= 1'b0;
            snd_reg   <= 1'b0;
            bv_reg    <= 1'b0;
            bd_reg    <= 8'h00;
            res_reg   <= RES_OK;
            cnt_reg   <= '0;
            fin_reg   <= 1'b0;
            busy      <= 1'b0;
        end
        else
        begin
            st_reg    <= st_next;
            idx_reg   <= idx_next;
            start_reg <= start_next;
            snd_reg   <= snd_next;
            bv_reg    <= bv_next;
            bd_reg    <= bd_next;
            res_reg   <= res_next;
            cnt_reg   <= cnt_next;
            fin_reg   <= fin_next;
            busy      <= (st_next != H_IDLE);
        end
    end

    assign link.cmdStart  = start_reg;
    assign link.cmdIsSend = snd_reg;
    assign link.byteValid = bv_reg;
    assign link.byteData  = bd_reg;
    assign finished       = fin_reg;
    assign result         = res_reg;
    assign newCnt         = cnt_reg;
endmodule

// ---- sim/paw_link_chk.sv ----
/* Checker for the link between host end and device end.
   Assumes the bench wires it to the one paw_if instance. */
`timescale 1ns/1ns
module paw_link_chk
(
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       cmdStart,
    input  wire logic       cmdIsSend,
    input  wire logic       byteValid,
    input  wire logic [7:0] byteData,
    input  wire logic       rspValid,
    input  wire logic [7:0] rspData,
    input  wire logic       cmdDone,
    input  wire logic       cmdOk
);
    logic [8:0] byteCnt_reg;
    logic [8:0] byteCnt_next;
    logic [8:0] rspCnt_reg;
    logic [8:0] rspCnt_next;
    // Bytes seen since the last command start
    always_comb
    begin
        byteCnt_next = byteCnt_reg + 9'(byteValid);
        rspCnt_next  = rspCnt_reg + 9'(rspValid);
        if (cmdStart || !rst_n)
        begin
            byteCnt_next = '0;
            rspCnt_next  = '0;
        end
    end
    always_ff @(posedge mclk)
    begin
        byteCnt_reg <= byteCnt_next;
        rspCnt_reg  <= rspCnt_next;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    done_ok_a: assert property (cmdDone |-> cmdOk)
        else $error("done without ok");
    ok_with_done_a: assert property (cmdOk |-> cmdDone)
        else $error("ok without done");
    done_single_a: assert property (cmdDone |=> !cmdDone)
        else $error("done longer than a cycle");
    send_done_a: assert property (
        byteValid && byteCnt_reg == 9'd259 |-> ##3 cmdDone)
        else $error("send not completed three cycles after last byte");
    send_len_a: assert property (
        cmdDone |-> byteCnt_reg == 9'd0 || byteCnt_reg == 9'd260)
        else $error("send frame length wrong");
    rsp_len_a: assert property (
        cmdDone |-> rspCnt_reg == 9'd0
            || (rspValid && rspCnt_reg == 9'd255))
        else $error("response frame length wrong");
    rsp_type_a: assert property (
        cmdStart && !cmdIsSend |-> ##2 (rspValid && rspData == 8'h03)
            ##1 (rspValid && rspData == 8'h00))
        else $error("response type not 0300h");
    rsp_target_a: assert property (
        rspValid && rspCnt_reg == 9'd32 |-> rspData == 8'h00)
        else $error("response target byte not zero");
    rsp_excl_a: assert property (rspValid |-> !byteValid && !cmdStart)
        else $error("request during response");
    cover property (cmdStart && cmdIsSend);
    cover property (byteValid && byteCnt_reg == 9'd1 && byteData == 8'h05);
    cover property (cmdDone && rspValid && rspCnt_reg == 9'd255);
endmodule

// ---- sim/protected_area_auth_write_test.sv ----
/* Testbench: host end and device end joined by paw_if, driven by go.
   Assumes the bench fold model mirrors the device's own tag check. */
`timescale 1ns/1ns
module protected_area_auth_write_test
    import paw_pkg::*;
;
    logic         mclk = 0, rst_n = 0, go = 0, snoop = 0, statusRd = 0;
    logic         progFail = 0, genFail = 0, busy, finished, irq;
    logic [31:0]  addr = 0, curCnt = 0, data = 0, areaAddr = 32'h3;
    logic [31:0]  newCnt, wcntOut, areaWord;
    logic [127:0] nonce = 128'h00112233445566778899aabbccddeeff;
    logic [255:0] tag = 0, tagCalc;
    logic [15:0]  result;
    logic [7:0]   maskIn = 0, status;
    int           k = 0;
    int           n_fail = 0, num_checks = 0, cyc = 0;
    paw_if link();
    paw_host #(.BLK(4)) paw_host_inst (.link(link), .mclk(mclk),
        .rst_n(rst_n), .go(go), .addr(addr), .curCnt(curCnt),
        .nonce(nonce), .data(data), .tag(tag), .busy(busy),
        .finished(finished), .result(result), .newCnt(newCnt));
    paw_device #(.DEPTH(16), .BLK(4)) paw_device_inst (.link(link),
        .mclk(mclk), .rst_n(rst_n), .progFail(progFail),
        .genFail(genFail), .statusRd(statusRd), .status(status),
        .irq(irq), .wcntOut(wcntOut), .areaWord(areaWord),
        .areaAddr(areaAddr), .maskIn(maskIn));
    paw_link_chk paw_link_chk_inst (.mclk(mclk), .rst_n(rst_n),
        .cmdStart(link.cmdStart), .cmdIsSend(link.cmdIsSend),
        .byteValid(link.byteValid), .byteData(link.byteData),
        .rspValid(link.rspValid), .rspData(link.rspData),
        .cmdDone(link.cmdDone), .cmdOk(link.cmdOk));
    always #2 mclk = ~mclk;
    // Fold of the sent write frame minus tag bytes, to learn the tag
    always @(posedge mclk)
    begin
        if (go)
            tagCalc <= '0;
        else if (snoop && link.byteValid && k < 260 && (k < 33 || k > 64))
            tagCalc <= {tagCalc[247:0], tagCalc[255:248] ^ link.byteData};
        k <= go ? 0 : k + int'(snoop && link.byteValid);
    end
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_fail++;
            $display("[FAIL] %0t timeout", $time);
            report_and_stop;
        end
    end
    task report_and_stop;
        $display("checks %0d fails %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task run;
        @(posedge mclk) go <= 1;
        @(posedge mclk) go <= 0;
        @(negedge mclk) chk(32'(busy), 32'h1);
        while (finished !== 1'b1)
            @(negedge mclk);
        @(negedge mclk);
    endtask
    // First pass with a zero tag learns the tag, second pass uses it
    task wr(input logic [31:0] a, input logic [31:0] c, input logic pf,
            input logic gf, input logic [15:0] exp);
        @(posedge mclk);
        addr <= a;
        curCnt <= c;
        data <= {24'h5a5a5a, a[7:0]};
        tag <= '0;
        snoop <= 1;
        progFail <= 0;
        genFail <= 0;
        run;
        chk(32'(result), a >= 16 ? RES_ADDRESS : RES_AUTH);
        @(posedge mclk);
        snoop <= 0;
        tag <= tagCalc;
        progFail <= pf;
        genFail <= gf;
        run;
        chk(32'(result), 32'(exp));
        $display("write test at address %0d done", a);
    endtask
    initial
    begin
        repeat (8) @(posedge mclk);
        rst_n <= 1;
        wr(3, 0, 0, 0, RES_OK);
        chk(newCnt, 32'h1);
        chk(wcntOut, 32'h1);
        chk(areaWord, 32'h5a5a5a03);
        wr(3, 0, 0, 0, RES_COUNTER);
        chk(wcntOut, 32'h1);
        wr(16, 1, 0, 0, RES_ADDRESS);
        wr(5, 1, 1, 0, RES_WRFAIL);
        wr(5, 1, 0, 1, RES_GENERAL);
        chk(wcntOut, 32'h1);
        chk(32'(irq), 32'h0);
        @(posedge mclk) maskIn <= 8'h01;
        repeat (3) @(negedge mclk);
        chk(32'(irq), 32'h1);
        chk(32'(status), 32'(STAT_ERR_BIT));
        @(posedge mclk) statusRd <= 1;
        @(posedge mclk) statusRd <= 0;
        repeat (2) @(negedge mclk);
        chk(32'(status), 32'h0);
        chk(32'(irq), 32'h0);
        $display("status test done");
        report_and_stop;
    end
endmodule
